// ---- verilog/dual_link_params.svh ----
// Purpose: Offsets, codes, reset values and step counts for the dual-link command block
// Assumes: Included by the package and the design modules
// Notes:   Definitions only
`ifndef DUAL_LINK_PARAMS_SVH
`define DUAL_LINK_PARAMS_SVH

// APB byte offsets
`define OFS_SELECT     8'h00
`define OFS_COMMAND    8'h04
`define OFS_SKEW_ARG   8'h08
`define OFS_RESPONSE   8'h0c
`define OFS_STATUS     8'h10
`define OFS_CONFIG     8'h14

// Command word fields
`define CMD_OP_LSB     0
`define CMD_ARG_LSB    8
`define CMD_QUERY_BIT  16
`define CMD_DEFLT_BIT  17

// Opcodes
`define OP_ALPHA       8'h01
`define OP_MONO        8'h02
`define OP_CONV_STATE  8'h03
`define OP_SAMPLE      8'h04
`define OP_STANDARD    8'h05
`define OP_SYNTH_STATE 8'h06
`define OP_SYNTH_SIG   8'h07
`define OP_SKEW        8'h08
`define OP_SHARED_LO   8'h10
`define OP_SHARED_HI   8'h1f

// Argument limits
`define ARG_BOOL_MAX   8'h03
`define ARG_ALPHA_MAX  8'h0b
`define ARG_SAMP_MAX   8'h08
`define ARG_STD_MAX    8'h0c
`define ARG_SIG_MAX    8'h17

// Sampling structure codes
`define SAMP_GBR444_12B  4'h0
`define SAMP_GBR444A_10B 4'h2
`define SAMP_YCB444A_10B 4'h5
`define SAMP_YCB422_10B  4'h7
`define SAMP_YCB422A_12B 4'h8
`define SAMP_GBR_LAST    4'h2

// Video standard codes 0..2 are the 1080 60p, 59.94p and 50p rasters
`define STD_PROG_HI_LAST 4'h2

// Reset and default values
`define RST_ALPHA      4'h0
`define RST_MONO       1'b0
`define RST_SAMPLE     4'h0
`define RST_STANDARD   4'h4
`define RST_SYNTH      1'b1
`define RST_SIGNAL     5'h02
`define RST_SKEW       5'sd0

// Link B skew: argument in units of 0.0001 us, one step is 0.0135 us
`define SKEW_STEP_E4   17'd135
`define SKEW_HALF_E4   17'd67
`define SKEW_MAX_STEPS 17'd15
`define SKEW_STEP_S16  16'sd135

// Pixel levels on 12 bits
`define LVL_BLACK      16'd256
`define LVL_SPAN       16'd3504
`define LVL_TENTHS     16'd10

`endif

// ---- verilog/dual_link_pkg.sv ----
// Purpose: Types and shared decode helpers for the dual-link command block
// Assumes: dual_link_params.svh on the include path
// Notes:   No timescale, package only
`include "dual_link_params.svh"

package dual_link_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } state_t;

  typedef logic [3:0] samp_t;
  typedef logic [3:0] std_t;
  typedef logic [3:0] alpha_t;

  function automatic logic is_gbr(input samp_t s);
    return s <= `SAMP_GBR_LAST;
  endfunction

  function automatic logic has_alpha(input samp_t s);
    return (s == `SAMP_GBR444A_10B) || (s == `SAMP_YCB444A_10B) ||
           (s == `SAMP_YCB422A_12B);
  endfunction

  function automatic logic is_prog_hi(input std_t s);
    return s <= `STD_PROG_HI_LAST;
  endfunction

endpackage

// ---- verilog/skew_quantizer.sv ----
// Purpose: Turns a signed skew in 0.0001 us units into whole clock-period steps
// Assumes: Pure combinational, registered by the caller
// Notes:   Rounds half away from zero, then clamps to the step range
`timescale 1ns/100ps
`default_nettype none
`include "dual_link_params.svh"

module skew_quantizer (
  input  wire logic signed [15:0] usec_e4,
  output logic signed [4:0]       steps
);

  logic signed [16:0] wide;
  logic        [16:0] mag;
  logic        [16:0] quo;

  always_comb begin
    wide = 17'(usec_e4);
    mag  = wide[16] ? 17'(-wide) : 17'(wide);
    quo  = (mag + `SKEW_HALF_E4) / `SKEW_STEP_E4;
    if (quo > `SKEW_MAX_STEPS) begin // R16 R19
      quo = `SKEW_MAX_STEPS;
    end
    steps = wide[16] ? -$signed({1'b0, quo[3:0]}) : $signed({1'b0, quo[3:0]});
  end

endmodule
`default_nettype wire

// ---- verilog/pixel_mapper.sv ----
// Purpose: Applies mono copy and alpha fill to one pixel
// Assumes: Inputs come from logic on the same clock
// Notes:   Combinational; the caller registers the result
`timescale 1ns/100ps
`default_nettype none
`include "dual_link_params.svh"

module pixel_mapper (
  input  wire logic [3:0]  samp,
  input  wire logic        mono,
  input  wire logic [3:0]  alpha_src,
  input  wire logic [11:0] in_g,
  input  wire logic [11:0] in_b,
  input  wire logic [11:0] in_r,
  output logic      [11:0] out_g,
  output logic      [11:0] out_b,
  output logic      [11:0] out_r,
  output logic      [11:0] out_a
);

  function automatic logic [11:0] flat_level(input logic [3:0] code);
    logic [15:0] n;
    n = 16'(code) - 16'd1;
    return 12'(`LVL_BLACK + (n * `LVL_SPAN) / `LVL_TENTHS);
  endfunction

  always_comb begin
    out_g = in_g;
    out_b = in_b;
    out_r = in_r;
    // YCbCr structures pass untouched whatever the mono setting
    if (mono && dual_link_pkg::is_gbr(samp)) begin
      out_b = in_g; // R6
      out_r = in_g; // R6
    end
    // Alpha only exists on the three +A structures
    if (!dual_link_pkg::has_alpha(samp)) begin
      out_a = 12'(`LVL_BLACK); // R17
    end else if (alpha_src == 4'h0) begin
      out_a = in_g; // R5
    end else begin
      out_a = flat_level(alpha_src); // R5
    end
  end

endmodule
`default_nettype wire

// ---- verilog/dual_link_output_command_control.sv ----
// Purpose: APB command interpreter for the dual-link output settings
// Assumes: Pixel inputs come from logic on this clock; APB master on this clock
// Notes:   A command runs one cycle after its APB write completes
//
// Functional notes
// (R1) Host selects this module first; commands before selection are dropped.
// (R2) Commands shared with other modules are accepted without error.
// (R3) Boolean arguments accept numeric 1 or keyword ON equally.
// (R4) Default keyword restores the setting to its default value.
// (R5) Alpha comes from luma/green samples or a 0-100% flat field in 10% steps.
// (R6) Mono mode with GBR output copies green into blue and red.
// (R7) YCbCr output passes video unchanged whatever the mono mode.
// (R8) Conversion state query returns video standard and sampling structure.
// (R9) Sampling structure selects one of nine output structures.
// (R10) Every setting has a query returning the value in effect.
// (R11) Video standard selects one of thirteen 1080-line rasters.
// (R12) Synthesizer state switches the pattern synthesizer on or off.
// (R13) Test signal picks one of twenty-four synthesizer patterns.
// (R14) Link B skew is set in microseconds, applied in whole clock cycles.
// (R15) Skew query returns the skew currently applied.
// (R16) Skew spans plus/minus 0.2025 us in 0.0135 us steps.
// (R17) Alpha source only affects the three alpha-carrying structures.
// (R18) 1080 50/59.94/60p forces YCbCr 4:2:2 10 bit and refuses others.
// (R19) Requested skew is rounded to nearest cycle and clamped to range.
`timescale 1ns/100ps
`default_nettype none
`include "dual_link_params.svh"

module dual_link_output_command_control (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pix_in_valid,
  input  wire logic [11:0] pix_in_g,
  input  wire logic [11:0] pix_in_b,
  input  wire logic [11:0] pix_in_r,
  output logic             pix_out_valid,
  output logic      [11:0] pix_out_g,
  output logic      [11:0] pix_out_b,
  output logic      [11:0] pix_out_r,
  output logic      [11:0] pix_out_a,
  output logic      [3:0]  alpha_sel,
  output logic             mono_copy_mode,
  output logic      [3:0]  sample_struct,
  output logic      [3:0]  video_std,
  output logic             synth_on,
  output logic      [4:0]  test_signal,
  output logic signed [4:0] link_b_skew
);

  // APB group
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  // Command group
  dual_link_pkg::state_t state_r, state_nxt;
  logic        selected_r, selected_nxt;
  logic [17:0] cmd_r, cmd_nxt;
  logic [15:0] skew_arg_r, skew_arg_nxt;
  logic [31:0] resp_r, resp_nxt;
  logic        err_r, err_nxt;
  logic [3:0]  alpha_r, alpha_nxt;
  logic        mono_r, mono_nxt;
  logic [3:0]  samp_r, samp_nxt;
  logic [3:0]  std_r, std_nxt;
  logic        synth_r, synth_nxt;
  logic [4:0]  sig_r, sig_nxt;
  logic signed [4:0] skew_r, skew_nxt;
  // Pixel group and quantized skew
  logic        pv_r;
  logic [11:0] pg_r, pb_r, pr_r, pa_r;
  logic [11:0] map_g, map_b, map_r, map_a;
  logic signed [4:0] skew_q;

  logic        acc_first;
  logic        acc_done;
  logic        wr_done;
  logic [7:0]  op;
  logic [7:0]  arg;
  logic        is_query;
  logic        is_deflt;
  logic        err_set;

  assign acc_first = psel && penable && !pready_r;
  assign acc_done  = psel && penable && pready_r;
  assign wr_done   = acc_done && pwrite;
  assign op        = cmd_r[`CMD_OP_LSB +: 8];
  assign arg       = cmd_r[`CMD_ARG_LSB +: 8];
  assign is_query  = cmd_r[`CMD_QUERY_BIT];
  assign is_deflt  = cmd_r[`CMD_DEFLT_BIT];

  function automatic logic addr_hit(input logic [7:0] a);
    return (a == `OFS_SELECT) || (a == `OFS_COMMAND) || (a == `OFS_SKEW_ARG) ||
           (a == `OFS_RESPONSE) || (a == `OFS_STATUS) || (a == `OFS_CONFIG);
  endfunction

  function automatic logic [31:0] skew_units(input logic signed [4:0] s);
    logic signed [15:0] w;
    w = 16'(s) * `SKEW_STEP_S16;
    return {{16{w[15]}}, w};
  endfunction

  skew_quantizer u_quant (
    .usec_e4 (skew_arg_r),
    .steps   (skew_q)
  );

  pixel_mapper u_map (
    .samp      (samp_r),
    .mono      (mono_r),
    .alpha_src (alpha_r),
    .in_g      (pix_in_g),
    .in_b      (pix_in_b),
    .in_r      (pix_in_r),
    .out_g     (map_g),
    .out_b     (map_b),
    .out_r     (map_r),
    .out_a     (map_a)
  );

  // APB slave: one wait state, read data valid with pready
  always_comb begin
    pready_nxt  = acc_first;
    pslverr_nxt = acc_first && !addr_hit(paddr);
    prdata_nxt  = 32'h0000_0000;
    if (acc_first && !pwrite) begin
      case (paddr)
        `OFS_SELECT:   prdata_nxt = {31'h0000_0000, selected_r};
        `OFS_SKEW_ARG: prdata_nxt = {16'h0000, skew_arg_r};
        `OFS_RESPONSE: prdata_nxt = resp_r;
        `OFS_STATUS:   prdata_nxt = {30'h0000_0000, state_r == dual_link_pkg::ST_EXEC, err_r};
        `OFS_CONFIG:   prdata_nxt = {8'h00, skew_r, sig_r, synth_r, std_r, samp_r, mono_r,
                                     alpha_r};
        default:       prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // Command interpreter
  always_comb begin
    state_nxt    = state_r;
    selected_nxt = selected_r;
    cmd_nxt      = cmd_r;
    skew_arg_nxt = skew_arg_r;
    resp_nxt     = resp_r;
    alpha_nxt    = alpha_r;
    mono_nxt     = mono_r;
    samp_nxt     = samp_r;
    std_nxt      = std_r;
    synth_nxt    = synth_r;
    sig_nxt      = sig_r;
    skew_nxt     = skew_r;
    err_set      = 1'b0;
    if (wr_done) begin
      case (paddr)
        `OFS_SELECT:   selected_nxt = pwdata[0];
        `OFS_SKEW_ARG: skew_arg_nxt = pwdata[15:0];
        `OFS_COMMAND: begin
          // Unselected module ignores traffic meant for a sibling
          if (selected_r) begin // R1
            cmd_nxt   = pwdata[17:0];
            state_nxt = dual_link_pkg::ST_EXEC;
          end
        end
        default: ;
      endcase
    end
    case (state_r)
      dual_link_pkg::ST_IDLE: ;
      dual_link_pkg::ST_EXEC: begin
        state_nxt = dual_link_pkg::ST_IDLE;
        case (op)
          `OP_ALPHA: begin
            if (is_query) resp_nxt = {28'h0000000, alpha_r}; // R10
            else if (is_deflt) alpha_nxt = `RST_ALPHA; // R4
            else if (arg <= `ARG_ALPHA_MAX) alpha_nxt = arg[3:0]; // R5
            else err_set = 1'b1;
          end
          `OP_MONO: begin
            if (is_query) resp_nxt = {31'h00000000, mono_r}; // R10
            else if (is_deflt) mono_nxt = `RST_MONO; // R4
            else if (arg <= `ARG_BOOL_MAX) mono_nxt = arg[0]; // R3
            else err_set = 1'b1;
          end
          `OP_CONV_STATE: begin
            if (is_query) resp_nxt = {24'h000000, std_r, samp_r}; // R8
            else err_set = 1'b1;
          end
          `OP_SAMPLE: begin
            if (is_query) begin
              resp_nxt = {28'h0000000, samp_r}; // R10
            end else if (dual_link_pkg::is_prog_hi(std_r)) begin
              // Only 4:2:2 10 bit fits these rasters on a dual link
              if (is_deflt || arg[3:0] != `SAMP_YCB422_10B || arg > `ARG_SAMP_MAX)
                err_set = 1'b1; // R18
            end else if (is_deflt) begin
              samp_nxt = `RST_SAMPLE; // R4
            end else if (arg <= `ARG_SAMP_MAX) begin
              samp_nxt = arg[3:0]; // R9
            end else begin
              err_set = 1'b1;
            end
          end
          `OP_STANDARD: begin
            if (is_query) begin
              resp_nxt = {28'h0000000, std_r}; // R10
            end else if (is_deflt || arg <= `ARG_STD_MAX) begin
              std_nxt = is_deflt ? `RST_STANDARD : arg[3:0]; // R11
              if (dual_link_pkg::is_prog_hi(std_nxt))
                samp_nxt = `SAMP_YCB422_10B; // R18
            end else begin
              err_set = 1'b1;
            end
          end
          `OP_SYNTH_STATE: begin
            if (is_query) resp_nxt = {31'h00000000, synth_r}; // R10
            else if (is_deflt) synth_nxt = `RST_SYNTH; // R4
            else if (arg <= `ARG_BOOL_MAX) synth_nxt = arg[0]; // R12
            else err_set = 1'b1;
          end
          `OP_SYNTH_SIG: begin
            if (is_query) resp_nxt = {27'h0000000, sig_r}; // R10
            else if (is_deflt) sig_nxt = `RST_SIGNAL; // R4
            else if (arg <= `ARG_SIG_MAX) sig_nxt = arg[4:0]; // R13
            else err_set = 1'b1;
          end
          `OP_SKEW: begin
            if (is_query) resp_nxt = skew_units(skew_r); // R15
            else if (is_deflt) skew_nxt = `RST_SKEW; // R4
            else skew_nxt = skew_q; // R14 R19
          end
          default: begin
            // Shared platform commands are harmless here
            if (!(op >= `OP_SHARED_LO && op <= `OP_SHARED_HI)) // R2
              err_set = 1'b1;
          end
        endcase
      end
      default: state_nxt = dual_link_pkg::ST_IDLE;
    endcase
    // Set wins over a same-cycle write-one clear
    err_nxt = (err_r && !(wr_done && paddr == `OFS_STATUS && pwdata[0])) || err_set;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r    <= dual_link_pkg::ST_IDLE;
      selected_r <= 1'b0;
      cmd_r      <= 18'h00000;
      skew_arg_r <= 16'h0000;
      resp_r     <= 32'h0000_0000;
      err_r      <= 1'b0;
      alpha_r    <= `RST_ALPHA;
      mono_r     <= `RST_MONO;
      samp_r     <= `RST_SAMPLE;
      std_r      <= `RST_STANDARD;
      synth_r    <= `RST_SYNTH;
      sig_r      <= `RST_SIGNAL;
      skew_r     <= `RST_SKEW;
    end else begin
      state_r    <= state_nxt;
      selected_r <= selected_nxt;
      cmd_r      <= cmd_nxt;
      skew_arg_r <= skew_arg_nxt;
      resp_r     <= resp_nxt;
      err_r      <= err_nxt;
      alpha_r    <= alpha_nxt;
      mono_r     <= mono_nxt;
      samp_r     <= samp_nxt;
      std_r      <= std_nxt;
      synth_r    <= synth_nxt;
      sig_r      <= sig_nxt;
      skew_r     <= skew_nxt;
    end
  end

  // Pixel stage: one register, settings take effect on the next pixel
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pv_r <= 1'b0;
      pg_r <= 12'h000;
      pb_r <= 12'h000;
      pr_r <= 12'h000;
      pa_r <= 12'h000;
    end else begin
      pv_r <= pix_in_valid;
      if (pix_in_valid) begin
        pg_r <= map_g;
        pb_r <= map_b; // R6 R7
        pr_r <= map_r;
        pa_r <= map_a; // R5 R17
      end
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign pix_out_valid  = pv_r;
  assign pix_out_g      = pg_r;
  assign pix_out_b      = pb_r;
  assign pix_out_r      = pr_r;
  assign pix_out_a      = pa_r;
  assign alpha_sel      = alpha_r;
  assign mono_copy_mode = mono_r;
  assign sample_struct  = samp_r;
  assign video_std      = std_r;
  assign synth_on       = synth_r;
  assign test_signal    = sig_r;
  assign link_b_skew    = skew_r;

  // Assertions
  property p_unselected_drop;
    @(posedge clock) disable iff (!rst_n)
      (wr_done && paddr == `OFS_COMMAND && !selected_r) |=> state_r == dual_link_pkg::ST_IDLE;
  endproperty
  a_unselected_drop: assert property (p_unselected_drop) else $error("command ran unselected"); // R1

  property p_shared_no_err;
    @(posedge clock) disable iff (!rst_n)
      (state_r == dual_link_pkg::ST_EXEC && op >= `OP_SHARED_LO && op <= `OP_SHARED_HI)
      |=> err_r == $past(err_r);
  endproperty
  a_shared_no_err: assert property (p_shared_no_err) else $error("shared command raised error"); // R2

  property p_bool_equiv;
    @(posedge clock) disable iff (!rst_n)
      (state_r == dual_link_pkg::ST_EXEC && op == `OP_MONO && !is_query && !is_deflt &&
       arg <= `ARG_BOOL_MAX) |=> mono_r == $past(arg[0]);
  endproperty
  a_bool_equiv: assert property (p_bool_equiv) else $error("boolean argument misread"); // R3

  property p_default_alpha;
    @(posedge clock) disable iff (!rst_n)
      (state_r == dual_link_pkg::ST_EXEC && op == `OP_ALPHA && !is_query && is_deflt)
      |=> alpha_r == `RST_ALPHA;
  endproperty
  a_default_alpha: assert property (p_default_alpha) else $error("default not restored"); // R4

  property p_alpha_copy;
    @(posedge clock) disable iff (!rst_n)
      (pix_in_valid && dual_link_pkg::has_alpha(samp_r) && alpha_r == 4'h0)
      |=> pix_out_a == $past(pix_in_g) && pix_out_valid;
  endproperty
  a_alpha_copy: assert property (p_alpha_copy) else $error("alpha not copied from green"); // R5

  property p_mono_copy;
    @(posedge clock) disable iff (!rst_n)
      (pix_in_valid && mono_r && dual_link_pkg::is_gbr(samp_r))
      |=> pix_out_b == $past(pix_in_g) && pix_out_r == $past(pix_in_g);
  endproperty
  a_mono_copy: assert property (p_mono_copy) else $error("mono copy missing"); // R6

  property p_ycbcr_pass;
    @(posedge clock) disable iff (!rst_n)
      (pix_in_valid && !dual_link_pkg::is_gbr(samp_r))
      |=> pix_out_b == $past(pix_in_b) && pix_out_r == $past(pix_in_r);
  endproperty
  a_ycbcr_pass: assert property (p_ycbcr_pass) else $error("ycbcr video altered"); // R7

  property p_conv_state;
    @(posedge clock) disable iff (!rst_n)
      (state_r == dual_link_pkg::ST_EXEC && op == `OP_CONV_STATE && is_query)
      |=> resp_r[7:0] == {$past(std_r), $past(samp_r)};
  endproperty
  a_conv_state: assert property (p_conv_state) else $error("conversion state wrong"); // R8

  property p_skew_range;
    @(posedge clock) disable iff (!rst_n)
      skew_r >= -5'sd15 && skew_r <= 5'sd15;
  endproperty
  a_skew_range: assert property (p_skew_range) else $error("skew out of range"); // R16

  property p_skew_apply;
    @(posedge clock) disable iff (!rst_n)
      (state_r == dual_link_pkg::ST_EXEC && op == `OP_SKEW && !is_query && !is_deflt)
      |=> skew_r == $past(skew_q);
  endproperty
  a_skew_apply: assert property (p_skew_apply) else $error("skew not applied"); // R19

  property p_alpha_blank;
    @(posedge clock) disable iff (!rst_n)
      (pix_in_valid && !dual_link_pkg::has_alpha(samp_r)) |=> pix_out_a == 12'h100;
  endproperty
  a_alpha_blank: assert property (p_alpha_blank) else $error("alpha leaked"); // R17

  property p_prog_forced;
    @(posedge clock) disable iff (!rst_n)
      dual_link_pkg::is_prog_hi(std_r) |-> samp_r == `SAMP_YCB422_10B;
  endproperty
  a_prog_forced: assert property (p_prog_forced) else $error("1080p not forced to 422"); // R18

  c_exec_skew: cover property (@(posedge clock) disable iff (!rst_n)
    state_r == dual_link_pkg::ST_EXEC && op == `OP_SKEW);
  c_mono_gbr: cover property (@(posedge clock) disable iff (!rst_n)
    pix_in_valid && mono_r && dual_link_pkg::is_gbr(samp_r));
  c_refused: cover property (@(posedge clock) disable iff (!rst_n) !err_r ##1 err_r);

endmodule
`default_nettype wire

// ---- test/host_model.sv ----
// Purpose: Remote host model that issues APB transfers to the command block
// Assumes: Same clock as the block; the bench calls xfer
// Notes:   Released address and data are inverted so stale values never match
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic        clock,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  // Request held until pready is seen at a rising edge; the bench selects only after one unselected command
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    // No cycle count assumed: only the bench timeout ends a stuck wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- test/dual_link_output_command_control_test.sv ----
// Purpose: Self-checking bench for the dual-link command block
// Assumes: Host model drives APB; bench drives pixels
// Notes:   Expected results queue up and are popped when outputs appear
`timescale 1ns/100ps
`default_nettype none
`include "dual_link_params.svh"
module dual_link_output_command_control_test;
  logic              clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata;
  logic              pix_in_valid, pix_out_valid, mono_copy_mode, synth_on;
  logic [11:0]       pix_in_g, pix_in_b, pix_in_r, pix_out_g, pix_out_b, pix_out_r, pix_out_a;
  logic [3:0]        alpha_sel, sample_struct, video_std;
  logic [4:0]        test_signal;
  logic signed [4:0] link_b_skew;
  logic [47:0]       exp_q[$];
  logic [47:0]       pix_q[$];
  logic [47:0]       rd_exp;
  int                failures, checks, cyc;
  logic signed [15:0] sk_in [5] = '{16'sd269, 16'sd2020, -16'sd3000, 16'sd67, 16'sd68};
  int                sk_out [5] = '{270, 2025, -2025, 0, 135};

  host_model u_host (.clock, .pready, .psel, .penable, .pwrite, .paddr, .pwdata);
  dual_link_output_command_control dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pix_in_valid, .pix_in_g, .pix_in_b, .pix_in_r,
    .pix_out_valid, .pix_out_g, .pix_out_b, .pix_out_r, .pix_out_a, .alpha_sel,
    .mono_copy_mode, .sample_struct, .video_std, .synth_on, .test_signal, .link_b_skew);

  always #25 clock = ~clock;

  task test_done;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task cmp(input logic [47:0] e, input logic [47:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Read data and slave error are judged together, pixels on their own queue
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      rd_exp = exp_q.pop_front();
      cmp(rd_exp, {16'(pslverr), prdata});
      // Setting outputs must agree with the configuration word read back
      if (paddr == `OFS_CONFIG)
        cmp(rd_exp, {16'h0000, 8'h00, link_b_skew, test_signal, synth_on, video_std,
                     sample_struct, mono_copy_mode, alpha_sel});
    end
    if (pix_out_valid === 1'b1)
      cmp(pix_q.pop_front(), {pix_out_g, pix_out_b, pix_out_r, pix_out_a});
  end

  // Ceiling well above the roughly one thousand cycles the sequence needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      test_done;
    end
  end

  task wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [47:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, a, 32'h0);
  endtask
  task cmd(input logic [7:0] op, input logic [7:0] arg, input logic q, input logic d);
    wr(`OFS_COMMAND, {14'h0, d, q, arg, op});
  endtask
  task qry(input logic [7:0] op, input logic [47:0] e);
    cmd(op, 8'h00, 1'b1, 1'b0);
    rd(`OFS_RESPONSE, e);
  endtask
  task setq(input logic [7:0] op, input logic [7:0] arg, input logic [47:0] e);
    cmd(op, arg, 1'b0, 1'b0);
    qry(op, e);
  endtask
  // Random pixel; mono copies green, alpha is either green or a fixed level
  task px(input logic m, input logic cp, input logic [11:0] a);
    logic [11:0] g, b, r;
    g = 12'($urandom);
    b = 12'($urandom);
    r = 12'($urandom);
    pix_q.push_back({g, m ? g : b, m ? g : r, cp ? g : a});
    @(posedge clock);
    pix_in_valid <= 1'b1;
    pix_in_g     <= g;
    pix_in_b     <= b;
    pix_in_r     <= r;
    @(posedge clock);
    pix_in_valid <= 1'b0;
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    pix_in_valid = 1'b0;
    pix_in_g = 12'h000;
    pix_in_b = 12'h000;
    pix_in_r = 12'h000;
    failures = 0;
    checks = 0;
    cyc = 0;
    void'($urandom(38196));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    cmd(`OP_ALPHA, 8'h05, 1'b0, 1'b0);
    rd(`OFS_CONFIG, 48'ha800);
    wr(`OFS_SELECT, 32'h1);
    cmd(8'h15, 8'h00, 1'b0, 1'b0);
    rd(`OFS_STATUS, 48'h0);
    rd(8'h20, 48'h1_0000_0000);
    for (int i = 0; i < 4; i++) setq(`OP_MONO, 8'(i), 48'(i % 2));
    for (int i = 0; i < 12; i++) setq(`OP_ALPHA, 8'(i), 48'(i));
    cmd(`OP_ALPHA, 8'h03, 1'b0, 1'b1);
    qry(`OP_ALPHA, 48'h0);
    for (int i = 0; i < 24; i++) setq(`OP_SYNTH_SIG, 8'(i), 48'(i));
    for (int i = 2; i < 4; i++) setq(`OP_SYNTH_STATE, 8'(i), 48'(i - 2));
    for (int i = 0; i < 9; i++) setq(`OP_SAMPLE, 8'(i), 48'(i));
    for (int i = 12; i >= 0; i--) setq(`OP_STANDARD, 8'(i), 48'(i));
    qry(`OP_CONV_STATE, 48'h07);
    cmd(`OP_SAMPLE, 8'h00, 1'b0, 1'b0);
    rd(`OFS_STATUS, 48'h1);
    qry(`OP_SAMPLE, 48'h7);
    wr(`OFS_STATUS, 32'h1);
    cmd(`OP_STANDARD, 8'h00, 1'b0, 1'b1);
    qry(`OP_STANDARD, 48'h4);
    for (int i = 0; i < 5; i++) begin
      wr(`OFS_SKEW_ARG, 32'(sk_in[i]));
      cmd(`OP_SKEW, 8'h00, 1'b0, 1'b0);
      qry(`OP_SKEW, {16'h0, 32'(sk_out[i])});
    end
    cmd(8'h09, 8'h00, 1'b0, 1'b0);
    setq(`OP_ALPHA, 8'h0c, 48'h0);
    rd(`OFS_STATUS, 48'h1);
    wr(`OFS_STATUS, 32'h1);
    rd(`OFS_STATUS, 48'h0);
    cmd(`OP_SAMPLE, 8'h00, 1'b0, 1'b0);
    cmd(`OP_ALPHA, 8'd11, 1'b0, 1'b0);
    px(1'b1, 1'b0, 12'h100);
    cmd(`OP_SAMPLE, 8'h02, 1'b0, 1'b0);
    px(1'b1, 1'b0, 12'heb0);
    cmd(`OP_ALPHA, 8'h00, 1'b0, 1'b0);
    px(1'b1, 1'b1, 12'h000);
    cmd(`OP_SAMPLE, 8'h03, 1'b0, 1'b0);
    px(1'b0, 1'b0, 12'h100);
    rd(`OFS_CONFIG, 48'h0de870);
    repeat (4) @(posedge clock);
    test_done;
  end
endmodule
`default_nettype wire
